// ### count_pin_source.sv
// Pulse source standing at one count pin of the timer set
`timescale 1ns/1ps
`default_nettype none
module count_pin_source (
    input  wire logic       aclk,
    input  wire logic       en,
    input  wire logic       lvl,
    input  wire logic [7:0] hi,
    input  wire logic [7:0] lo,
    output logic            pin
);
    logic [7:0] cnt = 8'h00;
    initial pin = 1'h0;
    always @(posedge aclk) begin
        if (!en) begin
            pin <= lvl;
            cnt <= 8'h00;
        end else begin
            pin <= (cnt < hi);
            cnt <= (cnt + 8'h01 == hi + lo) ? 8'h00 : cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### multi_mode_timer_set.sv
// Three narrow reload timers and two wide multi-mode timers behind AXI4-Lite
//
// Contract
// (R01) Timer mode raises an interrupt request when the count underflows.
// (R02) Each underflow reloads the counter from its latch, giving periodic requests.
// (R03) Pulse output toggles its pin at every underflow of the driving timer.
// (R04) Event mode counts pulses on the first and second count pins.
// (R05) First wide timer measures high or low width on the first count pin.
// (R06) Second wide timer measures pulse period on the second count pin.
// (R07) Narrow timers divide their count source by written value plus one.
// (R08) Software accesses both bytes of a wide timer every time.
// (R09) Software reads high byte first, writes low byte first.
// (R10) Software never mixes read and write sequences on one wide timer.
// (R11) A latch-only write enters the counter at the reload after zero.
// (R12) Source switching keeps latches; software rewrites timers one, two, three.
// (R13) Timer, event and pulse modes read the live count.
// (R14) Measure modes read a holding register updated per finished measurement.
// (R15) Software sets port direction to output before pulse output use.
// (R16) Software sets port direction to input before counting or measuring.
// (R17) Software disables sub-oscillator drive when timer one counts sub-clock.
// (R18) Shared narrow output pin drives only while sub-oscillator is stopped.
// (R19) Continuous high-low mode requests second pin interrupt on both edges.
// (R20) High-byte read freezes low byte; low-byte write waits for high byte.
// (R21) Interrupt flags stay set until software clears them.
`timescale 1ns/1ps
`default_nettype none
module multi_mode_timer_set #(
    parameter int PRESCALE_W = 8
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [timer_set_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [timer_set_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [timer_set_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [timer_set_pkg::DATA_W-1:0]   s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          sub_clk_in,
    input  wire logic                          sub_osc_active,
    input  wire logic                          count_pin_first_in,
    output logic                               count_pin_first_out,
    output logic                               count_pin_first_oe_n,
    input  wire logic                          count_pin_second_in,
    output logic                               count_pin_second_out,
    output logic                               count_pin_second_oe_n,
    output logic                               second_wide_toggle_pin_out,
    output logic                               narrow_out_pin_out,
    output logic                               narrow_out_pin_oe_n,
    output logic [timer_set_pkg::FLAG_W-1:0]   irq_flags
);
    import timer_set_pkg::*;

    function automatic logic edge_hit(input logic prev, input logic cur, input logic rise);
        edge_hit = rise ? (!prev && cur) : (prev && !cur);
    endfunction

    // Pin synchronisers: stage one feeds stage two only
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] sync3_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            sync3_ff <= 4'h0;
        end else begin
            sync1_ff <= {sub_osc_active, sub_clk_in, count_pin_second_in, count_pin_first_in};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end
    wire pin0      = sync2_ff[0];
    wire pin1      = sync2_ff[1];
    wire sub_rise  = sync2_ff[2] && !sync3_ff[2];
    wire osc_run   = sync2_ff[3];
    wire any_edge0 = sync2_ff[0] ^ sync3_ff[0];
    wire any_edge1 = sync2_ff[1] ^ sync3_ff[1];

    // Software registers
    logic [7:0]            n_mode_ff;
    logic [7:0]            x_mode_ff;
    logic [7:0]            y_mode_ff;
    logic [PRESCALE_W-1:0] pre_div_ff;
    logic [PRESCALE_W-1:0] pre_cnt_ff;
    logic                  sub_half_ff;
    logic [FLAG_W-1:0]     flag_ff;
    logic [7:0]            x_wr_lo_ff;
    logic [7:0]            y_wr_lo_ff;
    logic [7:0]            x_rd_lo_ff;
    logic [7:0]            y_rd_lo_ff;
    logic [15:0]           x_hold_ff;
    logic [15:0]           y_hold_ff;

    wire [1:0] x_mode = x_mode_ff[W_MODE_LO +: 2];
    wire [1:0] y_mode = y_mode_ff[W_MODE_LO +: 2];
    wire       x_pol  = x_mode_ff[W_POL];
    wire       y_pol  = y_mode_ff[W_POL];

    // Count source ticks
    wire pre_tick = (pre_cnt_ff == '0);
    wire sub_tick = sub_rise && sub_half_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_ff  <= '0;
            sub_half_ff <= 1'b0;
        end else begin
            pre_cnt_ff  <= pre_tick ? pre_div_ff : pre_cnt_ff - 1'b1;
            sub_half_ff <= sub_half_ff ^ sub_rise;
        end
    end

    // AXI write path: address and data taken in either order
    logic                  aw_have_ff;
    logic                  w_have_ff;
    logic [ADDR_W-1:0]     aw_addr_ff;
    logic [DATA_W-1:0]     w_data_ff;
    logic                  w_lane0_ff;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire do_wr   = aw_have_ff && w_have_ff && !s_axi_bvalid;
    wire [7:0] wb = w_data_ff[7:0];
    wire wr_en   = do_wr && w_lane0_ff;
    wire wr_t1   = wr_en && (aw_addr_ff == OFS_T1);
    wire wr_t2   = wr_en && (aw_addr_ff == OFS_T2);
    wire wr_t3   = wr_en && (aw_addr_ff == OFS_T3);
    wire wr_nm   = wr_en && (aw_addr_ff == OFS_T123_MODE);
    wire wr_xlo  = wr_en && (aw_addr_ff == OFS_TX_LO);
    wire wr_xhi  = wr_en && (aw_addr_ff == OFS_TX_HI);
    wire wr_xm   = wr_en && (aw_addr_ff == OFS_TX_MODE);
    wire wr_ylo  = wr_en && (aw_addr_ff == OFS_TY_LO);
    wire wr_yhi  = wr_en && (aw_addr_ff == OFS_TY_HI);
    wire wr_ym   = wr_en && (aw_addr_ff == OFS_TY_MODE);
    wire wr_pre  = wr_en && (aw_addr_ff == OFS_PRESCALE);
    wire wr_clr  = wr_en && (aw_addr_ff == OFS_IRQ_STAT);
    wire wr_hit  = (aw_addr_ff <= OFS_IRQ_STAT) && (aw_addr_ff[1:0] == 2'h0);

    // Narrow timers
    logic [7:0] t1_cnt;
    logic [7:0] t2_cnt;
    logic [7:0] t3_cnt;
    logic       t1_uf;
    logic       t2_uf;
    logic       t3_uf;
    // (R12) Source select only steers ticks; latches untouched
    wire t1_tick = n_mode_ff[N_T1_SRC] ? pre_tick : sub_tick;
    wire t2_tick = n_mode_ff[N_T2_SRC] ? pre_tick : t1_uf;
    wire t3_tick = n_mode_ff[N_T3_SRC] ? pre_tick : t2_uf;
    wire n_lonly = n_mode_ff[N_LATCH_ONLY];

    reload_counter #(.W(8)) u_t1 (
        .aclk(aclk), .aresetn(aresetn), .tick(t1_tick), .restart(1'b0), .wr(wr_t1),
        .latch_only(n_lonly), .wr_value(wb), .count(t1_cnt), .underflow(t1_uf));
    reload_counter #(.W(8)) u_t2 (
        .aclk(aclk), .aresetn(aresetn), .tick(t2_tick), .restart(1'b0), .wr(wr_t2),
        .latch_only(n_lonly), .wr_value(wb), .count(t2_cnt), .underflow(t2_uf));
    reload_counter #(.W(8)) u_t3 (
        .aclk(aclk), .aresetn(aresetn), .tick(t3_tick), .restart(1'b0), .wr(wr_t3),
        .latch_only(n_lonly), .wr_value(wb), .count(t3_cnt), .underflow(t3_uf));

    // Wide timer X
    logic [15:0] x_cnt;
    logic        x_uf;
    wire x_edge = edge_hit(sync3_ff[0], pin0, x_pol);
    // (R05) Count while pin holds selected level; finish when it leaves
    wire x_meas_on  = (x_mode == WM_MEASURE) && (pin0 == x_pol);
    wire x_meas_end = (x_mode == WM_MEASURE) && edge_hit(sync3_ff[0], pin0, !x_pol);
    // (R04) Event mode counts first pin edges
    wire x_tick = !x_mode_ff[W_STOP] &&
                  ((x_mode == WM_EVENT) ? x_edge :
                   (x_mode == WM_MEASURE) ? (pre_tick && x_meas_on) : pre_tick);
    reload_counter #(.W(16)) u_tx (
        .aclk(aclk), .aresetn(aresetn), .tick(x_tick), .restart(x_meas_end),
        .wr(wr_xhi), .latch_only(x_mode_ff[W_LATCH_ONLY]), .wr_value({wb, x_wr_lo_ff}),
        .count(x_cnt), .underflow(x_uf));

    // Wide timer Y
    logic [15:0] y_cnt;
    logic        y_uf;
    wire y_edge  = edge_hit(sync3_ff[1], pin1, y_pol);
    wire y_hl    = (y_mode == WM_MEASURE);
    // (R06) Period ends at each active edge; high-low at every edge
    wire y_meas_end = ((y_mode == WM_PERIOD) && y_edge) || (y_hl && any_edge1);
    wire y_tick = !y_mode_ff[W_STOP] && ((y_mode == WM_EVENT) ? y_edge : pre_tick);
    reload_counter #(.W(16)) u_ty (
        .aclk(aclk), .aresetn(aresetn), .tick(y_tick), .restart(y_meas_end),
        .wr(wr_yhi), .latch_only(y_mode_ff[W_LATCH_ONLY]), .wr_value({wb, y_wr_lo_ff}),
        .count(y_cnt), .underflow(y_uf));

    // (R13) Live count versus (R14) held measurement
    wire [15:0] x_view = (x_mode == WM_MEASURE) ? x_hold_ff : x_cnt;
    wire [15:0] y_view = (y_mode == WM_PERIOD || y_hl) ? y_hold_ff : y_cnt;

    // Interrupt events; measure modes report completion instead of underflow
    wire [FLAG_W-1:0] events;
    assign events[F_T1] = t1_uf;
    assign events[F_T2] = t2_uf;
    assign events[F_T3] = t3_uf;
    assign events[F_TX] = (x_mode == WM_MEASURE) ? x_meas_end : x_uf;
    assign events[F_TY] = (y_mode == WM_PERIOD || y_hl) ? y_meas_end : y_uf;
    assign events[F_C0] = x_edge;
    // (R19) Both edges raise the second pin request in high-low mode
    assign events[F_C1] = y_hl ? any_edge1 : y_edge;

    wire [FLAG_W-1:0] clr_mask = wr_clr ? wb[FLAG_W-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_ff   <= '0;
            x_hold_ff <= 16'h0000;
            y_hold_ff <= 16'h0000;
        end else begin
            // (R21) Sticky flags; a new event beats the clear
            flag_ff <= (flag_ff & ~clr_mask) | events;
            if (x_meas_end) begin
                x_hold_ff <= x_cnt;
            end
            if (y_meas_end) begin
                y_hold_ff <= y_cnt;
            end
        end
    end

    // Mode registers and the buffered low bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            n_mode_ff  <= RST_MODE;
            x_mode_ff  <= RST_MODE;
            y_mode_ff  <= RST_MODE;
            pre_div_ff <= RST_PRESCALE[PRESCALE_W-1:0];
            x_wr_lo_ff <= 8'h00;
            y_wr_lo_ff <= 8'h00;
        end else begin
            if (wr_nm)  n_mode_ff  <= wb;
            if (wr_xm)  x_mode_ff  <= wb;
            if (wr_ym)  y_mode_ff  <= wb;
            if (wr_pre) pre_div_ff <= wb[PRESCALE_W-1:0];
            // (R20) Low byte waits for the high-byte write
            if (wr_xlo) x_wr_lo_ff <= wb;
            if (wr_ylo) y_wr_lo_ff <= wb;
        end
    end

    // Write handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff    <= 1'b0;
            w_have_ff     <= 1'b0;
            aw_addr_ff    <= '0;
            w_data_ff     <= '0;
            w_lane0_ff    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_ff && !aw_take;
            s_axi_wready  <= !w_have_ff && !w_take;
            if (aw_take) begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                w_have_ff  <= 1'b1;
                w_data_ff  <= s_axi_wdata;
                w_lane0_ff <= s_axi_wstrb[0];
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_ff   <= 1'b0;
                w_have_ff    <= 1'b0;
            end
        end
    end

    // Read path; high-byte reads snapshot the low byte
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [ADDR_W-1:0] ra = s_axi_araddr;
    logic [7:0] rd_byte;
    logic       rd_hit;
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (ra)
            OFS_T1:        rd_byte = t1_cnt;
            OFS_T2:        rd_byte = t2_cnt;
            OFS_T3:        rd_byte = t3_cnt;
            OFS_T123_MODE: rd_byte = n_mode_ff;
            OFS_TX_LO:     rd_byte = x_rd_lo_ff;
            OFS_TX_HI:     rd_byte = x_view[15:8];
            OFS_TX_MODE:   rd_byte = x_mode_ff;
            OFS_TY_LO:     rd_byte = y_rd_lo_ff;
            OFS_TY_HI:     rd_byte = y_view[15:8];
            OFS_TY_MODE:   rd_byte = y_mode_ff;
            OFS_PRESCALE:  rd_byte = 8'(pre_div_ff);
            OFS_IRQ_STAT:  rd_byte = 8'(flag_ff);
            default:       rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
            x_rd_lo_ff    <= 8'h00;
            y_rd_lo_ff    <= 8'h00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                // (R20) Freeze low byte on high-byte read
                if (ra == OFS_TX_HI) x_rd_lo_ff <= x_view[7:0];
                if (ra == OFS_TY_HI) y_rd_lo_ff <= y_view[7:0];
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Pin drivers
    wire n_uf = n_mode_ff[N_OUT_SEL] ? t2_uf : t1_uf;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_pin_first_out        <= 1'b0;
            count_pin_first_oe_n       <= 1'b1;
            count_pin_second_out       <= 1'b0;
            count_pin_second_oe_n      <= 1'b1;
            second_wide_toggle_pin_out <= 1'b0;
            narrow_out_pin_out         <= 1'b0;
            narrow_out_pin_oe_n        <= 1'b1;
            irq_flags                  <= '0;
        end else begin
            // (R03) Toggle on each underflow of the driving timer
            if (x_uf && x_mode == WM_PULSE) count_pin_first_out <= !count_pin_first_out;
            if (y_uf && y_mode_ff[W_TOGGLE_EN]) begin
                second_wide_toggle_pin_out <= !second_wide_toggle_pin_out;
            end
            if (n_uf && n_mode_ff[N_OUT_EN]) narrow_out_pin_out <= !narrow_out_pin_out;
            count_pin_first_oe_n  <= (x_mode != WM_PULSE);
            // Second count pin is input-only here; its pulse output is the toggle pin
            count_pin_second_oe_n <= 1'b1;
            count_pin_second_out  <= 1'b0;
            // (R18) No drive while the sub-oscillator runs
            narrow_out_pin_oe_n   <= !(n_mode_ff[N_OUT_EN] && !osc_run);
            irq_flags             <= flag_ff;
        end
    end
endmodule
`default_nettype wire

// ### multi_mode_timer_set_checker.sv
// Bus and pin assertions for the timer set
`timescale 1ns/1ps
`default_nettype none
module multi_mode_timer_set_checker (
    input wire logic                             aclk,
    input wire logic                             aresetn,
    input wire logic                             s_axi_awvalid,
    input wire logic                             s_axi_awready,
    input wire logic                             s_axi_wready,
    input wire logic                             s_axi_bvalid,
    input wire logic                             s_axi_arvalid,
    input wire logic                             s_axi_arready,
    input wire logic [timer_set_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic                             s_axi_rvalid,
    input wire logic                             sub_osc_active,
    input wire logic                             count_pin_second_oe_n,
    input wire logic                             narrow_out_pin_out,
    input wire logic                             narrow_out_pin_oe_n,
    input wire logic [timer_set_pkg::FLAG_W-1:0] irq_flags
);
    import timer_set_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read answer");
    a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:6] s_axi_bvalid)
        else $error("write response missing");
    a_write_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_byte_data: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_second_input: assert property (count_pin_second_oe_n)
        else $error("second count pin driven");
    a_osc_owns_pin: assert property (sub_osc_active [*4] |-> narrow_out_pin_oe_n)
        else $error("narrow pin driven, oscillator on");
    a_flags_sticky: assert property (|($past(irq_flags) & ~irq_flags)
        |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("flag dropped without write");
    c_read: cover property (s_axi_arvalid && s_axi_arready);
    c_toggle: cover property ($changed(narrow_out_pin_out));
    c_edge_flag: cover property (irq_flags[F_C1]);
endmodule
bind multi_mode_timer_set multi_mode_timer_set_checker u_chk (.*);
`default_nettype wire

// ### reload_counter.sv
// Down counter with reload latch, shared by the narrow and the wide timers
`timescale 1ns/1ps
`default_nettype none
module reload_counter #(
    parameter int W = 8
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         tick,
    input  wire logic         restart,
    input  wire logic         wr,
    input  wire logic         latch_only,
    input  wire logic [W-1:0] wr_value,
    output logic [W-1:0]      count,
    output logic              underflow
);
    logic [W-1:0] latch_ff;
    logic [W-1:0] count_ff;
    logic         at_zero;

    assign at_zero   = (count_ff == '0);
    // (R01) Underflow event
    assign underflow = tick && at_zero;
    assign count     = count_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_ff <= '1;
            count_ff <= '1;
        end else begin
            if (wr) begin
                latch_ff <= wr_value;
            end
            // (R11) Latch-only write waits for reload
            if (wr && !latch_only) begin
                count_ff <= wr_value;
            end else if (restart) begin
                count_ff <= latch_ff;
            end else if (tick) begin
                // (R02) Reload on underflow
                // (R07) Divide by n plus one
                count_ff <= at_zero ? latch_ff : count_ff - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb_multi_mode_timer_set.sv
// Self-checking bench for the timer set
`timescale 1ns/1ps
`default_nettype none
module tb_multi_mode_timer_set;
    import timer_set_pkg::*;
    `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
        $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
    logic aclk = 1'h0, aresetn = 1'h0, sub_clk_in = 1'h0, sub_osc_active = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, pen = 2'h0, plvl = 2'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic count_pin_first_in, count_pin_first_out, count_pin_first_oe_n;
    logic count_pin_second_in, count_pin_second_out, count_pin_second_oe_n;
    logic second_wide_toggle_pin_out, narrow_out_pin_out, narrow_out_pin_oe_n;
    logic [FLAG_W-1:0] irq_flags;
    wire [1:0] outs = {second_wide_toggle_pin_out, narrow_out_pin_out};
    logic [7:0] phi = 8'h04, plo = 8'h04;
    int mismatches = 0, check_count = 0, tmo = 0;
    int nv[3] = '{32'h0, 32'hFF, 32'h5};
    int pv[3] = '{32'h0, 32'h0, 32'h2};
    multi_mode_timer_set dut (.*);
    count_pin_source u_src0 (.aclk, .en(pen[0]), .lvl(plvl[0]), .hi(phi), .lo(plo),
        .pin(count_pin_first_in));
    count_pin_source u_src1 (.aclk, .en(pen[1]), .lvl(plvl[1]), .hi(phi), .lo(plo),
        .pin(count_pin_second_in));
    initial forever #2.5 aclk = ~aclk;
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        if (++tmo == 20000) begin
            mismatches++;
            results();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        `CHK(s_axi_bresp, r)
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] r, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        `CHK(s_axi_rresp, r)
    endtask
    task automatic wr16(input int k, input logic [15:0] d);
        wr(k ? OFS_TY_LO : OFS_TX_LO, {24'h0, d[7:0]});
        wr(k ? OFS_TY_HI : OFS_TX_HI, {24'h0, d[15:8]});
    endtask
    task automatic rd16(input int k, output logic [31:0] v);
        logic [31:0] h;
        rd(k ? OFS_TY_HI : OFS_TX_HI, RESP_OKAY, h);
        rd(k ? OFS_TY_LO : OFS_TX_LO, RESP_OKAY, v);
        v = {16'h0, h[7:0], v[7:0]};
    endtask
    // Cycles between two pin changes
    task automatic gap(input logic w, output int c);
        logic s0;
        s0 = outs[w];
        while (outs[w] === s0) @(posedge aclk);
        s0 = outs[w];
        for (c = 0; c == 0 || outs[w] === s0; c++) @(posedge aclk);
    endtask
    initial begin
        logic [31:0] v, m [2], y [2];
        int c;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (3) @(posedge aclk);
        rd(8'h30, RESP_SLVERR, v);
        `CHK(v, 32'h0)
        wr(8'h31, 32'h0, RESP_SLVERR);
        rd(OFS_T2, RESP_OKAY, v);
        `CHK(v, 32'hFF)
        wr(OFS_T123_MODE, 32'h24);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_PRESCALE, pv[i]);
            wr(OFS_T1, nv[i]);
            gap(1'h0, c);
            `CHK(c, (nv[i] + 1) * (pv[i] + 1))
        end
        `CHK(irq_flags[F_T1], 1'h1)
        `CHK(narrow_out_pin_oe_n, 1'h0)
        sub_osc_active <= 1'h1;
        repeat (5) @(posedge aclk);
        `CHK(narrow_out_pin_oe_n, 1'h1)
        wr(OFS_PRESCALE, 32'h0);
        wr16(0, 16'h0003);
        wr16(1, 16'h0003);
        wr(OFS_TY_MODE, 32'h20);
        gap(1'h1, c);
        `CHK(c, 4)
        `CHK(irq_flags[F_TX], 1'h1)
        wr(OFS_TX_MODE, 32'h08);
        `CHK(irq_flags[F_TX], 1'h1)
        wr(OFS_IRQ_STAT, 32'h08);
        repeat (3) @(posedge aclk);
        `CHK(irq_flags[F_TX], 1'h0)
        for (int k = 0; k < 2; k++) begin
            wr(k ? OFS_TY_MODE : OFS_TX_MODE, 32'h06);
            wr16(k, 16'h000A);
        end
        pen <= 2'h3;
        repeat (24) @(posedge aclk);
        pen <= 2'h0;
        repeat (4) @(posedge aclk);
        for (int k = 0; k < 2; k++) begin
            rd16(k, v);
            `CHK(v, 32'h7)
        end
        wr(OFS_TX_MODE, 32'h07);
        wr(OFS_TY_MODE, 32'h05);
        wr16(0, 16'hFFFF);
        wr16(1, 16'hFFFF);
        for (int r = 0; r < 2; r++) begin
            phi <= r ? 8'h28 : 8'h14;
            plo <= 8'h1E;
            pen <= 2'h3;
            repeat (200) @(posedge aclk);
            rd16(0, m[r]);
            rd16(1, y[r]);
            pen <= 2'h0;
            repeat (4) @(posedge aclk);
        end
        `CHK(m[0] - m[1], 32'h14)
        `CHK(y[0] - y[1], 32'h14)
        repeat (50) @(posedge aclk);
        rd16(1, v);
        `CHK(v, y[0] - 32'h14)
        wr(OFS_TY_MODE, 32'h07);
        plvl <= 2'h2;
        repeat (6) @(posedge aclk);
        wr(OFS_IRQ_STAT, 32'h7F);
        plvl <= 2'h0;
        repeat (6) @(posedge aclk);
        `CHK(irq_flags[F_C1], 1'h1)
        results();
    end
endmodule
`default_nettype wire

// ### timer_set_pkg.sv
// Package with the register map, field positions and modes of the timer set
package timer_set_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_T1       = 8'h00;
    localparam logic [7:0] OFS_T2       = 8'h04;
    localparam logic [7:0] OFS_T3       = 8'h08;
    localparam logic [7:0] OFS_T123_MODE = 8'h0C;
    localparam logic [7:0] OFS_TX_LO    = 8'h10;
    localparam logic [7:0] OFS_TX_HI    = 8'h14;
    localparam logic [7:0] OFS_TX_MODE  = 8'h18;
    localparam logic [7:0] OFS_TY_LO    = 8'h1C;
    localparam logic [7:0] OFS_TY_HI    = 8'h20;
    localparam logic [7:0] OFS_TY_MODE  = 8'h24;
    localparam logic [7:0] OFS_PRESCALE = 8'h28;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h2C;

    // Narrow timer mode register fields
    localparam int N_OUT_SEL   = 1;
    localparam int N_T1_SRC    = 2;
    localparam int N_T2_SRC    = 3;
    localparam int N_T3_SRC    = 4;
    localparam int N_OUT_EN    = 5;
    localparam int N_LATCH_ONLY = 6;

    // Wide timer mode register fields
    localparam int W_MODE_LO   = 0;
    localparam int W_POL       = 2;
    localparam int W_STOP      = 3;
    localparam int W_LATCH_ONLY = 4;
    localparam int W_TOGGLE_EN = 5;

    // Interrupt flag positions
    localparam int F_T1 = 0;
    localparam int F_T2 = 1;
    localparam int F_T3 = 2;
    localparam int F_TX = 3;
    localparam int F_TY = 4;
    localparam int F_C0 = 5;
    localparam int F_C1 = 6;
    localparam int FLAG_W = 7;

    // Reset values and bus response codes
    localparam logic [7:0]  RST_MODE     = 8'h00;
    localparam logic [7:0]  RST_PRESCALE = 8'h00;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Wide timer modes; the second timer reads mode 1 as period measurement
    localparam logic [1:0] WM_TIMER   = 2'h0;
    localparam logic [1:0] WM_PULSE   = 2'h1;
    localparam logic [1:0] WM_EVENT   = 2'h2;
    localparam logic [1:0] WM_MEASURE = 2'h3;
    localparam logic [1:0] WM_PERIOD  = 2'h1;
endpackage
